// File: priority_virtual_channel_flow.sv
`timescale 1ns/1ps
`default_nettype none
module priority_virtual_channel_flow (
	// Clock and reset
	input  wire logic                      ref_clk,
	input  wire logic                      rst,
	// Mode control for this link
	input  wire logic                      hp_enable_sw,
	input  wire logic                      warm_reset,
	input  wire logic                      host_pass_pw_mode,
	input  wire logic                      pass_posted_enable,
	output logic                           hp_mode,
	// Receive stream
	input  wire logic                      in_valid,
	output logic                           in_ready,
	input  wire vc_pkg::pkt_kind_t         in_kind,
	input  wire logic                      in_class,
	input  wire logic                      in_pass_pw,
	input  wire logic [vc_pkg::TAG_W-1:0]  in_tag,
	input  wire logic [vc_pkg::DATA_W-1:0] in_data,
	// Local responder
	input  wire logic                      lrsp_valid,
	output logic                           lrsp_ready,
	input  wire vc_pkg::pkt_kind_t         lrsp_kind,
	input  wire logic                      lrsp_pass_pw,
	input  wire logic [vc_pkg::TAG_W-1:0]  lrsp_tag,
	input  wire logic [vc_pkg::DATA_W-1:0] lrsp_data,
	// Transmit stream
	output logic                           out_valid,
	input  wire logic                      out_ready,
	output vc_pkg::pkt_kind_t              out_kind,
	output logic                           out_class,
	output logic                           out_pass_pw,
	output logic      [vc_pkg::TAG_W-1:0]  out_tag,
	output logic      [vc_pkg::DATA_W-1:0] out_data,
	output logic                           out_hp,
	output vc_pkg::chan_t                  out_chan,
	// Buffer release toward the sender
	output logic                           rel_valid,
	output logic                           rel_class,
	output vc_pkg::chan_t                  rel_chan
);

	// =========================================================
	// Declarations
	logic                        class_by_tag [2**vc_pkg::TAG_W];
	vc_pkg::pkt_kind_t           src_kind;
	logic                        src_class;
	logic                        src_pass_pw;
	logic [vc_pkg::TAG_W-1:0]    src_tag;
	logic [vc_pkg::DATA_W-1:0]   src_data;
	logic                        is_nop;
	logic                        src_hp;
	logic [2:0]                  src_q;
	logic                        accept;
	logic [vc_pkg::ENTRY_W-1:0]  push_entry;
	logic [5:0]                  q_push;
	logic [5:0]                  q_can;
	logic [5:0]                  q_has;
	logic [5:0]                  q_pop;
	logic [5:0]                  q_ok;
	logic [vc_pkg::ENTRY_W-1:0]  q_head [vc_pkg::NUM_Q];
	logic [vc_pkg::CREDIT_W-1:0] tx_credit [vc_pkg::NUM_Q];
	logic [2:0]                  grant_ord;
	logic [2:0]                  grant_hp;
	logic                        load;
	logic [2:0]                  pick_q;
	logic [vc_pkg::ENTRY_W-1:0]  pick_entry;

	// =========================================================
	// Mode enable: off after cold reset, latched at warm reset.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			hp_mode <= 1'b0; // [R7]
		else if (warm_reset)
			hp_mode <= hp_enable_sw; // [R7] [R11]
	end

	// =========================================================
	// Ingress: link traffic first, local responses fill idle cycles.
	always_comb begin
		if (in_valid) begin
			src_kind    = in_kind;
			src_class   = in_class; // [R13]
			src_pass_pw = in_pass_pw;
			src_tag     = in_tag;
			src_data    = in_data;
		end else begin
			src_kind    = lrsp_kind;
			src_class   = class_by_tag[lrsp_tag]; // [R14]
			src_pass_pw = lrsp_pass_pw || host_pass_pw_mode; // [R15]
			src_tag     = lrsp_tag;
			src_data    = lrsp_data;
		end
	end

	// Class steering: only eligible flagged packets enter high-priority queues.
	assign is_nop = in_valid && (in_kind == vc_pkg::PK_NOP);
	assign src_hp = hp_mode && src_class && !vc_pkg::hp_excluded(src_kind); // [R1] [R2] [R3] [R5] [R6] [R17]
	assign src_q  = vc_pkg::q_index(src_hp, vc_pkg::chan_of(src_kind));

	// Release packets are always taken; others wait for queue room.
	assign in_ready   = in_valid && (is_nop || q_can[src_q]);
	assign lrsp_ready = !in_valid && !warm_reset && q_can[src_q];
	assign accept     = !warm_reset && !is_nop &&
		((in_valid && q_can[src_q]) || (!in_valid && lrsp_valid && q_can[src_q]));
	assign q_push     = accept ? (6'h01 << src_q) : 6'h00;
	assign push_entry = {src_kind, src_class, src_pass_pw, src_tag, src_data};

	// Remembers the class flag of each received nonposted request.
	always_ff @(posedge ref_clk) begin
		if (accept && in_valid && vc_pkg::chan_of(in_kind) == vc_pkg::CH_NONPOSTED)
			class_by_tag[in_tag] <= in_class; // [R14]
	end

	// =========================================================
	// Six channel queues with their transmit credits.
	for (genvar g = 0; g < vc_pkg::NUM_Q; g++) begin : g_q
		localparam int CH = g % vc_pkg::NUM_CH;
		localparam logic HP = (g >= vc_pkg::NUM_CH);
		logic [vc_pkg::NOP_INC_W-1:0] inc;

		packet_queue u_queue (
			.ref_clk    (ref_clk),
			.rst        (rst),
			.clr        (warm_reset),
			.push_valid (q_push[g]),
			.push_ready (q_can[g]),
			.push_data  (push_entry),
			.pop_valid  (q_has[g]),
			.pop_ready  (q_pop[g]),
			.pop_data   (q_head[g])
		); // [R1]

		// Credit returned by a release packet of the matching class.
		assign inc = (in_valid && is_nop && ((in_class && hp_mode) == HP)) ? // [R4]
			in_data[vc_pkg::NOP_INC_LSB + CH*vc_pkg::NOP_INC_W +: vc_pkg::NOP_INC_W] :
			'0;

		// Credit counter: release adds, each send removes one.
		always_ff @(posedge ref_clk or posedge rst) begin
			if (rst)
				tx_credit[g] <= vc_pkg::CREDIT_INIT;
			else if (warm_reset)
				tx_credit[g] <= vc_pkg::CREDIT_INIT;
			else
				tx_credit[g] <= tx_credit[g] + vc_pkg::CREDIT_W'(inc) -
					vc_pkg::CREDIT_W'(q_pop[g]);
		end

		assign q_ok[g] = (tx_credit[g] != '0);
	end

	// =========================================================
	// Ordering inside each class uses the same picker.
	order_pick u_pick_ord (
		.has         (q_has[2:0]),
		.credit_ok   (q_ok[2:0]),
		.rsp_pass_pw (q_head[vc_pkg::CH_RESPONSE][vc_pkg::ENT_PPW_BIT]),
		.pass_enable (pass_posted_enable),
		.grant       (grant_ord)
	);

	order_pick u_pick_hp (
		.has         (q_has[5:3]),
		.credit_ok   (q_ok[5:3]),
		.rsp_pass_pw (q_head[3 + vc_pkg::CH_RESPONSE][vc_pkg::ENT_PPW_BIT]),
		.pass_enable (pass_posted_enable),
		.grant       (grant_hp)
	); // [R9]

	// Strict priority between classes, with no fairness throttle.
	assign load  = !warm_reset && (!out_valid || out_ready);
	assign q_pop = !load ? 6'h00 :
		(|grant_hp) ? {grant_hp, 3'h0} : {3'h0, grant_ord}; // [R8] [R10]

	// Index of the queue being drained this cycle.
	always_comb begin
		pick_q = 3'h0;
		for (int i = 0; i < vc_pkg::NUM_Q; i++) begin
			if (q_pop[i])
				pick_q = 3'(i);
		end
	end
	assign pick_entry = q_head[pick_q];

	// =========================================================
	// Transmit register: holds a packet until the link takes it.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			out_valid   <= 1'b0;
			out_kind    <= vc_pkg::PK_READ;
			out_class   <= 1'b0;
			out_pass_pw <= 1'b0;
			out_tag     <= '0;
			out_data    <= '0;
			out_hp      <= 1'b0;
			out_chan    <= vc_pkg::CH_POSTED;
		end else if (warm_reset) begin
			out_valid <= 1'b0;
		end else if (|q_pop) begin
			out_valid   <= 1'b1;
			out_kind    <= vc_pkg::pkt_kind_t'(pick_entry[vc_pkg::ENT_KIND_LSB +: 4]);
			out_class   <= pick_entry[vc_pkg::ENT_CLASS_BIT]; // [R13] [R17]
			out_pass_pw <= pick_entry[vc_pkg::ENT_PPW_BIT];
			out_tag     <= pick_entry[vc_pkg::ENT_TAG_LSB +: vc_pkg::TAG_W];
			out_data    <= pick_entry[vc_pkg::ENT_DATA_LSB +: vc_pkg::DATA_W];
			out_hp      <= (pick_q >= 3'h3);
			out_chan    <= vc_pkg::chan_t'(2'((pick_q >= 3'h3) ? pick_q - 3'h3 : pick_q));
		end else if (out_ready) begin
			out_valid <= 1'b0;
		end
	end

	// Release of the receive buffer just freed; class only on high-priority queues.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rel_valid <= 1'b0;
			rel_class <= 1'b0;
			rel_chan  <= vc_pkg::CH_POSTED;
		end else begin
			rel_valid <= |q_pop;
			rel_class <= (|q_pop) && (pick_q >= 3'h3) && hp_mode; // [R12]
			rel_chan  <= vc_pkg::chan_t'(2'((pick_q >= 3'h3) ? pick_q - 3'h3 : pick_q));
		end
	end

	// =========================================================
	// Checks
	AST_COLD_OFF: assert property (@(posedge ref_clk) disable iff (rst) // [R7]
		!hp_mode && !warm_reset |=> !hp_mode)
		else $error("mode changed without warm reset");

	AST_WARM_ON: assert property (@(posedge ref_clk) disable iff (rst) // [R7]
		warm_reset |=> hp_mode == $past(hp_enable_sw))
		else $error("warm reset did not load mode enable");

	AST_NO_HP_EXCLUDED: assert property (@(posedge ref_clk) disable iff (rst) // [R5]
		accept && vc_pkg::hp_excluded(src_kind) |-> q_push[5:3] == 3'h0)
		else $error("broadcast or atomic entered high-priority queue");

	AST_FENCE_CLASS: assert property (@(posedge ref_clk) disable iff (rst) // [R6]
		accept && (src_kind == vc_pkg::PK_FENCE || src_kind == vc_pkg::PK_FLUSH) &&
		!src_class |-> q_push[5:3] == 3'h0)
		else $error("unflagged fence or flush entered high-priority queue");

	AST_OFF_ORDINARY: assert property (@(posedge ref_clk) disable iff (rst) // [R17]
		!hp_mode |-> q_push[5:3] == 3'h0 && !(out_valid && out_hp))
		else $error("high-priority queue used with mode off");

	AST_HP_FIRST: assert property (@(posedge ref_clk) disable iff (rst) // [R10]
		load && |(q_has[5:3] & q_ok[5:3]) |-> q_pop[2:0] == 3'h0)
		else $error("ordinary queue served while high-priority pending");

	AST_HP_FLAGGED: assert property (@(posedge ref_clk) disable iff (rst) // [R2]
		out_valid && out_hp |-> out_class && !vc_pkg::hp_excluded(out_kind))
		else $error("unflagged packet sent from high-priority channel");

	AST_REL_NORMAL: assert property (@(posedge ref_clk) disable iff (rst) // [R12]
		!hp_mode && !$past(hp_mode) && rel_valid |-> !rel_class)
		else $error("flagged release sent in normal mode");

	AST_RSP_FLAG: assert property (@(posedge ref_clk) disable iff (rst) // [R14]
		lrsp_valid && lrsp_ready && class_by_tag[lrsp_tag] |->
		push_entry[vc_pkg::ENT_CLASS_BIT])
		else $error("response lost class flag of its request");

	AST_HOST_PPW: assert property (@(posedge ref_clk) disable iff (rst) // [R15]
		lrsp_valid && lrsp_ready && host_pass_pw_mode |-> push_entry[vc_pkg::ENT_PPW_BIT])
		else $error("host mode response without pass flag");

	AST_PASS_POSTED: assert property (@(posedge ref_clk) disable iff (rst) // [R16]
		q_pop[vc_pkg::CH_RESPONSE] && q_has[vc_pkg::CH_POSTED] |->
		pass_posted_enable && q_head[vc_pkg::CH_RESPONSE][vc_pkg::ENT_PPW_BIT])
		else $error("response passed posted without pass flag");

	// Stream, credit, ordering, release and warm reset checks.
	AST_CREDIT_HELD: assert property (@(posedge ref_clk) disable iff (rst) // [R1]
		(q_pop & ~q_ok) == 6'h00)
		else $error("queue drained without transmit credit");

	AST_ONE_SEND: assert property (@(posedge ref_clk) disable iff (rst) // [R10]
		$onehot0(q_pop))
		else $error("more than one queue drained in a cycle");

	AST_NP_AFTER_POSTED: assert property (@(posedge ref_clk) disable iff (rst) // [R9]
		!(q_pop[vc_pkg::CH_NONPOSTED] && q_has[vc_pkg::CH_POSTED]) &&
		!(q_pop[3 + vc_pkg::CH_NONPOSTED] && q_has[3 + vc_pkg::CH_POSTED]))
		else $error("nonposted request passed a posted request");

	AST_NOP_NOT_QUEUED: assert property (@(posedge ref_clk) disable iff (rst) // [R4]
		is_nop |-> q_push == 6'h00)
		else $error("buffer release packet entered a queue");

	AST_OUT_HOLD: assert property (@(posedge ref_clk) disable iff (rst) // [R13]
		out_valid && !out_ready && !warm_reset |=>
		out_valid && $stable(out_kind) && $stable(out_class) && $stable(out_tag) &&
		$stable(out_data) && $stable(out_pass_pw))
		else $error("transmit packet changed before it was taken");

	AST_WARM_EMPTY: assert property (@(posedge ref_clk) disable iff (rst) // [R7]
		warm_reset |=> !out_valid && q_has == 6'h00)
		else $error("warm reset left traffic behind");

endmodule : priority_virtual_channel_flow
`default_nettype wire

// File: vc_pkg.sv
// Functional notes
// (R1) High-priority mode gives posted, nonposted and response channels with separate buffers.
// (R2) Reads and writes with the class flag set enter the high-priority request channels.
// (R3) Read responses and target-done packets with the flag set use the high-priority response channel.
// (R4) A buffer-release packet with the flag set returns credits of high-priority channels.
// (R5) Broadcast and atomic packets never enter or affect the high-priority channels.
// (R6) Fence and flush use the high-priority channels only when their flag is one.
// (R7) Mode is off after cold reset; the enable takes effect at a warm reset.
// (R8) No ordering between the two classes; high-priority traffic sees no fairness logic.
// (R9) Inside the high-priority class the ordinary channel ordering applies unchanged.
// (R10) Pending high-priority traffic is always served before ordinary traffic.
// (R11) Each link holds its own high-priority enable, so tagged traffic can tunnel.
// (R12) In normal mode every buffer-release packet carries the class flag at zero.
// (R13) In normal mode the class flag is carried through unchanged.
// (R14) A response to a flagged nonposted request carries the flag as well.
// (R15) Optional host mode sets the pass-posted-write flag in every issued response.
// (R16) Responses with the pass-posted-write flag may overtake stalled posted requests.
// (R17) With the mode off, flagged packets queue in ordinary channels, flag retained.
`default_nettype none
package vc_pkg;

	// =========================================================
	// Packet kinds and channels
	typedef enum logic [3:0] {
		PK_READ      = 4'h0,
		PK_WRITE_P   = 4'h1,
		PK_WRITE_NP  = 4'h2,
		PK_RD_RSP    = 4'h3,
		PK_TGT_DONE  = 4'h4,
		PK_BROADCAST = 4'h5,
		PK_ATOMIC    = 4'h6,
		PK_FENCE     = 4'h7,
		PK_FLUSH     = 4'h8,
		PK_NOP       = 4'h9
	} pkt_kind_t;

	typedef enum logic [1:0] {
		CH_POSTED    = 2'h0,
		CH_NONPOSTED = 2'h1,
		CH_RESPONSE  = 2'h2
	} chan_t;

	// =========================================================
	// Widths, depths and reset values
	localparam int DATA_W      = 32;
	localparam int TAG_W       = 5;
	localparam int NUM_CH      = 3;
	localparam int NUM_Q       = 6;
	localparam int QUEUE_DEPTH = 4;
	localparam int PTR_W       = 2;
	localparam int CNT_W       = 3;
	localparam int CREDIT_W    = 4;
	localparam logic [CREDIT_W-1:0] CREDIT_INIT = 4'h8;

	// =========================================================
	// Queue entry layout
	localparam int ENT_DATA_LSB  = 0;
	localparam int ENT_TAG_LSB   = 32;
	localparam int ENT_PPW_BIT   = 37;
	localparam int ENT_CLASS_BIT = 38;
	localparam int ENT_KIND_LSB  = 39;
	localparam int ENTRY_W       = 43;

	// =========================================================
	// Credit increments in a buffer-release payload, two bits per channel
	localparam int NOP_INC_LSB = 0;
	localparam int NOP_INC_W   = 2;

	// Maps a packet kind to its virtual channel type.
	function automatic chan_t chan_of(input pkt_kind_t k);
		case (k)
			PK_WRITE_P, PK_BROADCAST, PK_FENCE: chan_of = CH_POSTED;
			PK_RD_RSP, PK_TGT_DONE: chan_of = CH_RESPONSE;
			default: chan_of = CH_NONPOSTED;
		endcase
	endfunction : chan_of

	// Kinds that may never travel in the high-priority channels.
	function automatic logic hp_excluded(input pkt_kind_t k);
		hp_excluded = (k == PK_BROADCAST) || (k == PK_ATOMIC);
	endfunction : hp_excluded

	// Queue index: ordinary channels 0..2, high-priority channels 3..5.
	function automatic logic [2:0] q_index(input logic hp, input chan_t c);
		q_index = (hp ? 3'h3 : 3'h0) + {1'b0, c};
	endfunction : q_index

endpackage : vc_pkg
`default_nettype wire

// File: packet_queue.sv
`timescale 1ns/1ps
`default_nettype none
module packet_queue (
	// Clock and reset
	input  wire logic                       ref_clk,
	input  wire logic                       rst,
	input  wire logic                       clr,
	// Fill side
	input  wire logic                       push_valid,
	output logic                            push_ready,
	input  wire logic [vc_pkg::ENTRY_W-1:0] push_data,
	// Drain side
	output logic                            pop_valid,
	input  wire logic                       pop_ready,
	output logic      [vc_pkg::ENTRY_W-1:0] pop_data
);

	// =========================================================
	// Storage
	logic [vc_pkg::ENTRY_W-1:0] mem [vc_pkg::QUEUE_DEPTH];
	logic [vc_pkg::PTR_W-1:0]   wr_ptr;
	logic [vc_pkg::PTR_W-1:0]   rd_ptr;
	logic [vc_pkg::CNT_W-1:0]   count;
	logic                       do_push;
	logic                       do_pop;

	// Full and empty follow the entry count.
	assign push_ready = (count != vc_pkg::CNT_W'(vc_pkg::QUEUE_DEPTH));
	assign pop_valid  = (count != '0);
	assign pop_data   = mem[rd_ptr];
	assign do_push    = push_valid && push_ready;
	assign do_pop     = pop_valid && pop_ready;

	// Pointers and count; a warm reset empties the queue.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else if (clr) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (do_push)
				wr_ptr <= wr_ptr + 2'h1;
			if (do_pop)
				rd_ptr <= rd_ptr + 2'h1;
			count <= count + vc_pkg::CNT_W'(do_push) - vc_pkg::CNT_W'(do_pop);
		end
	end

	// Entry write.
	always_ff @(posedge ref_clk) begin
		if (do_push)
			mem[wr_ptr] <= push_data;
	end

endmodule : packet_queue
`default_nettype wire

// File: order_pick.sv
`timescale 1ns/1ps
`default_nettype none
module order_pick (
	// Channel state, index by vc_pkg::chan_t
	input  wire logic [2:0] has,
	input  wire logic [2:0] credit_ok,
	input  wire logic       rsp_pass_pw,
	input  wire logic       pass_enable,
	// Chosen channel, one-hot
	output logic      [2:0] grant
);

	logic p_go;
	logic n_go;
	logic r_go;

	// Posted goes first; responses pass nonposted; nonposted waits on posted.
	assign p_go = has[vc_pkg::CH_POSTED] && credit_ok[vc_pkg::CH_POSTED];
	assign r_go = has[vc_pkg::CH_RESPONSE] && credit_ok[vc_pkg::CH_RESPONSE] &&
		(!has[vc_pkg::CH_POSTED] || (pass_enable && rsp_pass_pw)); // [R16]
	assign n_go = has[vc_pkg::CH_NONPOSTED] && credit_ok[vc_pkg::CH_NONPOSTED] &&
		!has[vc_pkg::CH_POSTED];

	// Fixed priority among the three channels of one class.
	always_comb begin
		grant = 3'h0;
		if (p_go)
			grant[vc_pkg::CH_POSTED] = 1'b1;
		else if (r_go)
			grant[vc_pkg::CH_RESPONSE] = 1'b1;
		else if (n_go)
			grant[vc_pkg::CH_NONPOSTED] = 1'b1;
	end

endmodule : order_pick
`default_nettype wire

// File: link_partner.sv
`timescale 1ns/1ps
`default_nettype none
module link_partner (
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic rst,
	// Stall request from the bench
	input  wire logic hold,
	// Transmit stream handshake
	output logic      out_ready
);
	// =========================================================
	// Receiver of the far node
	// Accepts about three cycles in four, so the block meets back-pressure at random.
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			out_ready <= 1'b0;
		end else begin
			out_ready <= #1 !hold && ($urandom % 4 != 0);
		end
	end
endmodule : link_partner
`default_nettype wire

// File: tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	// =========================================================
	// Signals
	logic                      ref_clk, rst, hp_enable_sw, warm_reset, host_pass_pw_mode;
	logic                      pass_posted_enable, hp_mode, hold, hpm;
	logic                      in_valid, in_ready, in_class, in_pass_pw;
	logic                      lrsp_valid, lrsp_ready, lrsp_pass_pw;
	logic                      out_valid, out_ready, out_class, out_pass_pw, out_hp;
	logic                      rel_valid, rel_class;
	vc_pkg::pkt_kind_t         in_kind, lrsp_kind, out_kind;
	vc_pkg::chan_t             out_chan, rel_chan;
	logic [vc_pkg::TAG_W-1:0]  in_tag, lrsp_tag, out_tag;
	logic [vc_pkg::DATA_W-1:0] in_data, lrsp_data, out_data;
	logic [45:0]               exp_q[$];
	int                        num_errors, checked, cycles;

	priority_virtual_channel_flow i_dut (.ref_clk, .rst, .hp_enable_sw, .warm_reset,
		.host_pass_pw_mode, .pass_posted_enable, .hp_mode, .in_valid, .in_ready, .in_kind,
		.in_class, .in_pass_pw, .in_tag, .in_data, .lrsp_valid, .lrsp_ready, .lrsp_kind,
		.lrsp_pass_pw, .lrsp_tag, .lrsp_data, .out_valid, .out_ready, .out_kind, .out_class,
		.out_pass_pw, .out_tag, .out_data, .out_hp, .out_chan, .rel_valid, .rel_class,
		.rel_chan);
	link_partner i_partner (.ref_clk, .rst, .hold, .out_ready);

	// Clock generator, 40 ns period.
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	// =========================================================
	// Helpers
	// Packs the expected output fields; channel and class worked out independently.
	function automatic logic [45:0] pk(vc_pkg::pkt_kind_t k, logic c, logic p, logic [4:0] t,
		logic [31:0] d);
		logic [1:0] ch;
		logic       h;
		ch = (k == vc_pkg::PK_WRITE_P || k == vc_pkg::PK_BROADCAST || k == vc_pkg::PK_FENCE)
			? 2'h0 : (k == vc_pkg::PK_RD_RSP || k == vc_pkg::PK_TGT_DONE) ? 2'h2 : 2'h1;
		h = hpm && c && !(k == vc_pkg::PK_BROADCAST || k == vc_pkg::PK_ATOMIC);
		pk = {k, c, p, t, d, h, ch};
	endfunction : pk

	// Compares one value and counts it.
	task automatic check(string name, logic [45:0] seen, logic [45:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h, seen %h", name, exp, seen);
		end
	endtask : check

	// Offers one packet on the receive stream and notes its expected output.
	task automatic send(vc_pkg::pkt_kind_t k, logic c, logic p, logic [4:0] t, logic [31:0] d,
		bit note);
		int n;
		@(posedge ref_clk);
		#1;
		in_kind = k;
		{in_class, in_pass_pw, in_tag, in_data, in_valid} = {c, p, t, d, 1'b1};
		n = 0;
		@(negedge ref_clk);
		while (in_ready !== 1'b1 && n < 100) begin
			n++;
			@(negedge ref_clk);
		end
		if (n == 100) num_errors++;
		if (note && k != vc_pkg::PK_NOP) exp_q.push_back(pk(k, c, p, t, d));
		@(posedge ref_clk);
		#1 in_valid = 1'b0;
	endtask : send

	// Sends a packet, then a buffer release for the credit it will use.
	task automatic xfer(vc_pkg::pkt_kind_t k, logic c, logic p, logic [4:0] t, logic [31:0] d);
		logic [45:0] e;
		e = pk(k, c, p, t, d);
		send(k, c, p, t, d, 1'b1);
		if (k != vc_pkg::PK_NOP) send(vc_pkg::PK_NOP, e[2], 1'b0, 5'h0, 32'h1 << (2 * e[1:0]), 0);
	endtask : xfer

	// Drives one local response through its handshake.
	task automatic lrsp(vc_pkg::pkt_kind_t k, logic c, logic p, logic [4:0] t, logic [31:0] d);
		int n;
		@(posedge ref_clk);
		#1;
		lrsp_kind = k;
		{lrsp_pass_pw, lrsp_tag, lrsp_data, lrsp_valid} = {p, t, d, 1'b1};
		n = 0;
		@(negedge ref_clk);
		while (lrsp_ready !== 1'b1 && n < 100) begin
			n++;
			@(negedge ref_clk);
		end
		if (n == 100) num_errors++;
		exp_q.push_back(pk(k, c, p | host_pass_pw_mode, t, d));
		@(posedge ref_clk);
		#1 lrsp_valid = 1'b0;
		send(vc_pkg::PK_NOP, hpm && c, 1'b0, 5'h0, 32'h10, 0);
	endtask : lrsp

	// Waits until at most the given number of noted packets remain; a hang counts.
	task automatic drain(int left);
		int n;
		n = 0;
		while (exp_q.size() > left && n < 300) begin
			n++;
			@(posedge ref_clk);
			#1;
		end
		if (n == 300) num_errors++;
	endtask : drain

	// Drains, then pulses warm reset so the software enable is loaded.
	task automatic warm();
		drain(0);
		@(posedge ref_clk);
		#1 warm_reset = 1'b1;
		@(posedge ref_clk);
		#1 warm_reset = 1'b0;
		hpm = hp_enable_sw;
	endtask : warm

	// Prints the counts and the verdict, then stops.
	task automatic complete_run();
		$display("comparisons %0d, mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : complete_run

	// =========================================================
	// Output monitor: each accepted packet takes the oldest note.
	always @(posedge ref_clk) begin
		if (!rst && out_valid === 1'b1 && out_ready === 1'b1) begin
			if (exp_q.size() == 0) check("spare_packet", 46'h1, 46'h0);
			else check("packet", {out_kind, out_class, out_pass_pw, out_tag, out_data, out_hp, out_chan}, exp_q.pop_front());
		end
		if (!rst && rel_valid === 1'b1 && !hpm) check("rel_class", {45'h0, rel_class}, 46'h0);
		if (!rst && rel_valid === 1'b1)
			check("rel", 46'({rel_class, rel_chan}), 46'({out_hp && hpm, out_chan}));
	end

	// Cuts a hang short.
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			complete_run();
		end
	end

	// =========================================================
	// Main sequence
	initial begin
		{rst, hold, hpm} = 3'b110;
		{hp_enable_sw, warm_reset, host_pass_pw_mode, pass_posted_enable} = 4'h0;
		{in_valid, in_class, in_pass_pw, lrsp_valid, lrsp_pass_pw} = 5'h0;
		in_kind = vc_pkg::PK_READ;
		lrsp_kind = vc_pkg::PK_READ;
		{in_tag, lrsp_tag} = 10'h0;
		{in_data, lrsp_data} = 64'h0;
		{num_errors, checked, cycles} = 0;
		void'($urandom(43));
		repeat (10) @(posedge ref_clk);
		#1 rst = 1'b0;
		check("hp_mode", {45'h0, hp_mode}, 46'h0);
		hp_enable_sw = 1'b1;
		repeat (3) @(posedge ref_clk);
		check("hp_mode", {45'h0, hp_mode}, 46'h0);
		warm();
		@(negedge ref_clk);
		check("hp_mode", {45'h0, hp_mode}, 46'h1);
		$display("test mode enable done");
		for (int m = 0; m < 2; m++) begin
			hp_enable_sw = m[0];
			warm();
			hold = 1'b0;
			repeat (30) xfer(vc_pkg::pkt_kind_t'(4'($urandom % 9)), 1'($urandom), 1'($urandom),
				5'($urandom), $urandom);
			xfer(vc_pkg::PK_READ, 1'b1, 1'b0, 5'h07, 32'h1234_5678);
			host_pass_pw_mode = 1'b1;
			lrsp(vc_pkg::PK_RD_RSP, 1'b1, 1'b0, 5'h07, 32'h0bad_cafe);
			host_pass_pw_mode = 1'b0;
			xfer(vc_pkg::PK_WRITE_NP, 1'b0, 1'b0, 5'h08, 32'h0000_00aa);
			lrsp(vc_pkg::PK_TGT_DONE, 1'b0, 1'b0, 5'h08, 32'h0);
			drain(0);
			$display("test random traffic mode %0d done", m);
		end
		for (int en = 0; en < 3; en++) begin
			pass_posted_enable = en[0];
			warm();
			// Uses up all but one ordinary posted credit, so the second of the later posted pair stalls.
			repeat (int'(vc_pkg::CREDIT_INIT) - 1)
				send(vc_pkg::PK_WRITE_P, 1'b0, 1'b0, 5'($urandom), $urandom, 1);
			drain(0);
			hold = 1'b1;
			send(vc_pkg::PK_WRITE_P, 1'b0, 1'b0, 5'h01, 32'ha, 0);
			send(vc_pkg::PK_WRITE_P, 1'b0, 1'b0, 5'h02, 32'hb, 0);
			if (en < 2) send(vc_pkg::PK_RD_RSP, 1'b0, 1'b1, 5'h03, 32'hc, 0);
			else send(vc_pkg::PK_WRITE_P, 1'b1, 1'b0, 5'h03, 32'hc, 0);
			exp_q.push_back(pk(vc_pkg::PK_WRITE_P, 1'b0, 1'b0, 5'h01, 32'ha));
			if (en == 0) exp_q.push_back(pk(vc_pkg::PK_WRITE_P, 1'b0, 1'b0, 5'h02, 32'hb));
			if (en < 2) exp_q.push_back(pk(vc_pkg::PK_RD_RSP, 1'b0, 1'b1, 5'h03, 32'hc));
			else exp_q.push_back(pk(vc_pkg::PK_WRITE_P, 1'b1, 1'b0, 5'h03, 32'hc));
			if (en != 0) exp_q.push_back(pk(vc_pkg::PK_WRITE_P, 1'b0, 1'b0, 5'h02, 32'hb));
			hold = 1'b0;
			drain((en == 0) ? 2 : 1);
			send(vc_pkg::PK_NOP, 1'b0, 1'b0, 5'h0, 32'h1, 0);
			drain(0);
			$display("test ordering case %0d done", en);
		end
		complete_run();
	end
endmodule : tb
`default_nettype wire
